//--- core/pei_top.sv
// Decided for this implementation: the APB register port.
module pei_top #(
    parameter int FC_W = pei_pkg::PEI_FC_W,
    parameter int RE_W = pei_pkg::PEI_RE_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pei_pkg::PEI_ADDR_W-1:0] paddr,
    input wire logic [pei_pkg::PEI_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [pei_pkg::PEI_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic link_up,
    input wire logic speed_100,
    input wire logic full_duplex,
    input wire logic aneg_done,
    input wire logic [FC_W-1:0] false_carrier_counter,
    input wire logic [RE_W-1:0] rx_error_counter,
    input wire logic col_raw,
    output logic col_to_mac,
    input wire logic irq_or_powerdown_pin_i,
    output logic irq_or_powerdown_pin_o,
    output logic irq_or_powerdown_pin_oe,
    output logic powerdown_req
);
    import pei_pkg::*;

    // --------------------------------------------------------------
    // Elaboration checks
    // --------------------------------------------------------------
    if (FC_W < 2 || FC_W > 16)
    begin : g_fc_chk
        $error("FC_W out of range");
    end
    if (RE_W < 2 || RE_W > 32)
    begin : g_re_chk
        $error("RE_W out of range");
    end

    localparam logic [FC_W-1:0] FC_HALF = {1'b0, {(FC_W-1){1'b1}}};
    localparam logic [RE_W-1:0] RE_HALF = {1'b0, {(RE_W-1){1'b1}}};

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    logic [4:0] ctrl_reg;
    logic [PEI_EV_N-1:0] stat_reg;
    logic [PEI_EV_N-1:0] stat_next;
    logic [PEI_EV_N-1:0] en_reg;
    logic [PEI_EV_N-1:0] snap_reg;
    logic snap_valid_reg;
    logic link_q_reg;
    logic speed_q_reg;
    logic duplex_q_reg;
    logic aneg_q_reg;
    logic fc_over_q_reg;
    logic re_over_q_reg;
    logic [PEI_SYNC_N-1:0] pin_sync_reg;
    logic [PEI_EV_N-1:0] events;
    logic fc_over;
    logic re_over;
    logic setup;
    logic access_done;
    logic irq_active;
    logic pd_level;

    function automatic logic addr_hit(input logic [PEI_ADDR_W-1:0] a);
        addr_hit = (a == PEI_CTRL_ADDR) || (a == PEI_STAT_ADDR);
    endfunction

    assign setup = psel && !penable;
    assign access_done = psel && penable && pready;

    // --------------------------------------------------------------
    // Event detection
    // --------------------------------------------------------------
    assign fc_over = false_carrier_counter > FC_HALF;
    assign re_over = rx_error_counter > RE_HALF;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            link_q_reg <= 1'b0;
            speed_q_reg <= 1'b0;
            duplex_q_reg <= 1'b0;
            aneg_q_reg <= 1'b0;
            fc_over_q_reg <= 1'b0;
            re_over_q_reg <= 1'b0;
        end
        else
        begin
            link_q_reg <= link_up;
            speed_q_reg <= speed_100;
            duplex_q_reg <= full_duplex;
            aneg_q_reg <= aneg_done;
            fc_over_q_reg <= fc_over;
            re_over_q_reg <= re_over;
        end
    end

    always_comb
    begin
        events = '0;
        events[PEI_EV_LINK] = link_up ^ link_q_reg;
        events[PEI_EV_SPEED] = speed_100 ^ speed_q_reg;
        events[PEI_EV_DUPLEX] = full_duplex ^ duplex_q_reg;
        events[PEI_EV_ANEG] = aneg_done && !aneg_q_reg;
        events[PEI_EV_FC_HF] = fc_over && !fc_over_q_reg;
        events[PEI_EV_RE_HF] = re_over && !re_over_q_reg;
    end

    // --------------------------------------------------------------
    // Sticky status, clear on read of captured bits only
    // --------------------------------------------------------------
    always_comb
    begin
        stat_next = stat_reg;
        if (access_done && !pwrite && paddr == PEI_STAT_ADDR && snap_valid_reg)
        begin
            stat_next = stat_next & ~snap_reg;
        end
        stat_next = stat_next | events;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stat_reg <= PEI_STAT_RESET;
        end
        else
        begin
            stat_reg <= stat_next;
        end
    end

    // --------------------------------------------------------------
    // Register writes
    // --------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= PEI_CTRL_RESET;
        end
        else if (access_done && pwrite && paddr == PEI_CTRL_ADDR && pstrb[0])
        begin
            ctrl_reg <= pwdata[4:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en_reg <= PEI_EN_RESET;
        end
        else if (access_done && pwrite && paddr == PEI_STAT_ADDR && pstrb[0])
        begin
            en_reg <= pwdata[PEI_EN_LSB +: PEI_EV_N];
        end
    end

    // --------------------------------------------------------------
    // APB answer, no wait state
    // --------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup && !addr_hit(paddr);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= '0;
            snap_reg <= '0;
            snap_valid_reg <= 1'b0;
        end
        else if (setup)
        begin
            prdata <= '0;
            snap_reg <= '0;
            snap_valid_reg <= 1'b0;
            if (!pwrite && paddr == PEI_CTRL_ADDR)
            begin
                prdata[4:0] <= ctrl_reg;
            end
            else if (!pwrite && paddr == PEI_STAT_ADDR)
            begin
                prdata[PEI_STAT_LSB +: PEI_EV_N] <= stat_next;
                prdata[PEI_EN_LSB +: PEI_EV_N] <= en_reg;
                snap_reg <= stat_next;
                snap_valid_reg <= 1'b1;
            end
        end
    end

    // --------------------------------------------------------------
    // Collision gating
    // --------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            col_to_mac <= 1'b0;
        end
        else
        begin
            col_to_mac <= col_raw && (!full_duplex
                || ctrl_reg[PEI_CTRL_COLFD_BIT]);
        end
    end

    // --------------------------------------------------------------
    // Interrupt pin
    // --------------------------------------------------------------
    assign irq_active = ctrl_reg[PEI_CTRL_TEST_BIT]
        || (ctrl_reg[PEI_CTRL_GATE_BIT] && |(stat_reg & en_reg));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_or_powerdown_pin_o <= 1'b1;
            irq_or_powerdown_pin_oe <= 1'b0;
        end
        else
        begin
            irq_or_powerdown_pin_o <= irq_active ^ ctrl_reg[PEI_CTRL_POL_BIT];
            irq_or_powerdown_pin_oe <= ctrl_reg[PEI_CTRL_OE_BIT];
        end
    end

    // --------------------------------------------------------------
    // Power-down input path
    // --------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_sync_reg <= '1;
        end
        else
        begin
            pin_sync_reg <= {pin_sync_reg[PEI_SYNC_N-2:0], irq_or_powerdown_pin_i};
        end
    end

    assign pd_level = pin_sync_reg[PEI_SYNC_N-1];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            powerdown_req <= 1'b0;
        end
        else if (ctrl_reg[PEI_CTRL_OE_BIT])
        begin
            powerdown_req <= 1'b0;
        end
        else if (pin_sync_reg[1] == pd_level)
        begin
            powerdown_req <= !pd_level;
        end
    end

endmodule

//--- core/pei_pkg.sv
package pei_pkg;

    // --------------------------------------------------------------
    // Register map (index, byte address is four times it)
    // --------------------------------------------------------------
    localparam logic [7:0] PEI_CTRL_IDX = 8'h11;
    localparam logic [7:0] PEI_STAT_IDX = 8'h12;
    localparam logic [9:0] PEI_CTRL_ADDR = {PEI_CTRL_IDX, 2'b00};
    localparam logic [9:0] PEI_STAT_ADDR = {PEI_STAT_IDX, 2'b00};
    localparam int PEI_ADDR_W = 10;
    localparam int PEI_DATA_W = 32;

    // --------------------------------------------------------------
    // Control register fields
    // --------------------------------------------------------------
    localparam int PEI_CTRL_COLFD_BIT = 4;
    localparam int PEI_CTRL_POL_BIT = 3;
    localparam int PEI_CTRL_TEST_BIT = 2;
    localparam int PEI_CTRL_GATE_BIT = 1;
    localparam int PEI_CTRL_OE_BIT = 0;
    localparam logic [4:0] PEI_CTRL_RESET = 5'h08;

    // --------------------------------------------------------------
    // Status/enable register fields
    // --------------------------------------------------------------
    localparam int PEI_EV_N = 6;
    localparam int PEI_STAT_LSB = 8;
    localparam int PEI_EN_LSB = 0;
    localparam int PEI_EV_LINK = 5;
    localparam int PEI_EV_SPEED = 4;
    localparam int PEI_EV_DUPLEX = 3;
    localparam int PEI_EV_ANEG = 2;
    localparam int PEI_EV_FC_HF = 1;
    localparam int PEI_EV_RE_HF = 0;
    localparam logic [5:0] PEI_STAT_RESET = 6'h00;
    localparam logic [5:0] PEI_EN_RESET = 6'h00;

    // --------------------------------------------------------------
    // Counter widths
    // --------------------------------------------------------------
    localparam int PEI_FC_W = 8;
    localparam int PEI_RE_W = 16;

    // --------------------------------------------------------------
    // Pin synchroniser depth
    // --------------------------------------------------------------
    localparam int PEI_SYNC_N = 3;

endpackage

//--- test/pei_chk.sv
module pei_chk (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic [pei_pkg::PEI_ADDR_W-1:0] paddr,
    input logic [pei_pkg::PEI_DATA_W-1:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic full_duplex,
    input logic col_raw,
    input logic col_to_mac,
    input logic irq_or_powerdown_pin_o,
    input logic irq_or_powerdown_pin_oe
);
    import pei_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // Bus phases
    // ----------------------------------------
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_unmapped;
        s_setup ##0 (paddr != PEI_CTRL_ADDR && paddr != PEI_STAT_ADDR);
    endsequence
    sequence s_mapped;
        s_setup ##0 (paddr == PEI_CTRL_ADDR || paddr == PEI_STAT_ADDR);
    endsequence
    a_ready_after_setup: assert property (s_setup |=> pready)
        else $error("no pready after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_cause: assert property (pready |-> $past(psel && !penable))
        else $error("pready without setup");
    a_unmapped_err: assert property (s_unmapped |=> pslverr && prdata == '0)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (s_mapped |=> !pslverr)
        else $error("mapped access refused");
    a_reserved_zero: assert property (pready |-> prdata[31:14] == '0 && prdata[7:6] == '0)
        else $error("reserved bits not zero");
    a_col_half: assert property (col_raw && !full_duplex |=> col_to_mac)
        else $error("half duplex collision lost");
    a_col_idle: assert property (!col_raw |=> !col_to_mac)
        else $error("collision without cause");
    a_reset_idle: assert property ($rose(presetn) |-> irq_or_powerdown_pin_o
        && !irq_or_powerdown_pin_oe)
        else $error("pin not idle after reset");
endmodule

bind pei_top pei_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .full_duplex(full_duplex), .col_raw(col_raw), .col_to_mac(col_to_mac),
    .irq_or_powerdown_pin_o(irq_or_powerdown_pin_o),
    .irq_or_powerdown_pin_oe(irq_or_powerdown_pin_oe));

//--- test/pei_pin_model.sv
module pei_pin_model (
    input logic oe,
    input logic o,
    input logic pd_n,
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pull-up when released; host pulls low for power-down
    assign pin = oe ? o : pd_n;
endmodule

//--- test/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pei_pkg::*;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic col_raw = 1'h0;
    logic pd_n = 1'h1;
    logic [3:0] lv = 4'h0;
    logic [9:0] paddr = 10'h0;
    logic [31:0] pwdata = 32'h0;
    logic [7:0] fc = 8'h0;
    logic [15:0] re = 16'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, col_to_mac, pin, pin_o, pin_oe, pd_req, err;
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;

    pei_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link_up(lv[3]), .speed_100(lv[2]),
        .full_duplex(lv[1]), .aneg_done(lv[0]), .false_carrier_counter(fc),
        .rx_error_counter(re), .col_raw(col_raw), .col_to_mac(col_to_mac),
        .irq_or_powerdown_pin_i(pin), .irq_or_powerdown_pin_o(pin_o),
        .irq_or_powerdown_pin_oe(pin_oe), .powerdown_req(pd_req));
    pei_pin_model u_pin (.oe(pin_oe), .o(pin_o), .pd_n(pd_n), .pin(pin));

    // ----------------------------------------
    // Clock, timeout and report
    // ----------------------------------------
    initial
    begin
        forever #4 pclk = ~pclk;
    end
    task stop_test;
        if (errors == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            errors++;
            $display("ERROR %0t timeout", $time);
            stop_test;
        end
    end

    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic wchk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bchk(input logic got, input logic exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t pin %b expected %b", $time, got, exp);
        end
    endtask
    task automatic rx(input logic [9:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        wchk(rd, exp);
    endtask
    task automatic cy(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        bchk(pin_oe, 1'h0);
        rx(PEI_CTRL_ADDR, 32'h8);
        bchk(err, 1'h0);
        rx(PEI_STAT_ADDR, 32'h0);
        rx(10'h3fc, 32'h0);
        bchk(err, 1'h1);
        for (int i = 0; i < 4; i++)
        begin
            lv[i] <= 1'h1;
            cy(2);
            rx(PEI_STAT_ADDR, 32'h400 << i);
            rx(PEI_STAT_ADDR, 32'h0);
        end
        apb(1'h1, PEI_STAT_ADDR, 32'hffff);
        rx(PEI_STAT_ADDR, 32'h3f);
        apb(1'h1, PEI_CTRL_ADDR, 32'hf);
        cy(3);
        bchk(pin_o, 1'h0);
        bchk(pin_oe, 1'h1);
        apb(1'h1, PEI_CTRL_ADDR, 32'hb);
        cy(3);
        bchk(pin_o, 1'h1);
        lv[3] <= 1'h0;
        cy(3);
        bchk(pin_o, 1'h0);
        rx(PEI_STAT_ADDR, 32'h203f);
        cy(3);
        bchk(pin_o, 1'h1);
        apb(1'h1, PEI_CTRL_ADDR, 32'h3);
        cy(3);
        bchk(pin_o, 1'h0);
        lv[2] <= 1'h0;
        cy(3);
        bchk(pin_o, 1'h1);
        apb(1'h1, PEI_CTRL_ADDR, 32'h1);
        cy(3);
        bchk(pin_o, 1'h0);
        rx(PEI_STAT_ADDR, 32'h103f);
        fc <= 8'h7f;
        re <= 16'h7fff;
        cy(3);
        rx(PEI_STAT_ADDR, 32'h3f);
        fc <= 8'h80;
        re <= 16'h8000;
        cy(3);
        rx(PEI_STAT_ADDR, 32'h33f);
        col_raw <= 1'h1;
        cy(2);
        bchk(col_to_mac, 1'h0);
        apb(1'h1, PEI_CTRL_ADDR, 32'h11);
        cy(2);
        bchk(col_to_mac, 1'h1);
        apb(1'h1, PEI_CTRL_ADDR, 32'h1);
        lv[1] <= 1'h0;
        cy(2);
        bchk(col_to_mac, 1'h1);
        rx(PEI_STAT_ADDR, 32'h83f);
        col_raw <= 1'h0;
        apb(1'h1, PEI_CTRL_ADDR, 32'h0);
        pd_n <= 1'h0;
        cy(8);
        bchk(pd_req, 1'h1);
        pd_n <= 1'h1;
        cy(8);
        bchk(pd_req, 1'h0);
        stop_test;
    end
endmodule
